// ---- rtl/bpm_pkg.sv ----
// Constants, field layouts and carrier types for the beacon period manager.
// Assumes a 100 MHz ref_clk and a receive front end that decodes beacons.
package bpm_pkg;

	// ***************************************************************
	// Timing and sizing
	// ***************************************************************
	localparam int CLK_NS                    = 10;
	localparam int NSLOT                     = 16;
	localparam int SIG_SLOTS                 = 2;
	localparam int LOST_BEACON_LIMIT         = 3;
	localparam int MOVABLE_LATENCY_LIMIT     = 4;
	localparam int NEIGHBOUR_DETECT_INTERVAL = 8;
	localparam int MERGE_WAIT_TIME           = 8;
	localparam int MERGE_WAIT_LONG           = (MERGE_WAIT_TIME * 3) / 2;
	localparam int GUARD_INTERVAL_NS         = 12000;
	localparam int GUARD2_CYC = (2 * GUARD_INTERVAL_NS + CLK_NS - 1) / CLK_NS;
	localparam int BSLOT_NS                  = 85000;
	localparam int BSLOT_CYC                 = BSLOT_NS / CLK_NS;
	localparam int MSLOT_NS                  = 256000;
	localparam int MSLOT_CYC                 = MSLOT_NS / CLK_NS;
	localparam int SF_NS                     = 65536000;
	localparam int SF_CYC                    = SF_NS / CLK_NS;

	// ***************************************************************
	// Register map
	// ***************************************************************
	localparam logic [7:0]  ADDR_CTRL   = 8'h00;
	localparam logic [7:0]  ADDR_STATUS = 8'h04;
	localparam logic [7:0]  ADDR_SLOT   = 8'h08;
	localparam logic [7:0]  ADDR_RESV   = 8'h0c;
	localparam logic [7:0]  ADDR_RISK   = 8'h10;
	localparam int          CTRL_EN     = 0;
	localparam int          CTRL_HIB    = 1;
	localparam int          CTRL_CSWREQ = 2;
	localparam int          CTRL_LEN_LO = 8;
	localparam logic [31:0] CTRL_RST    = 32'h0000_0101;
	localparam logic [3:0]  SLOT_RST    = 4'h2;
	localparam int          ST_COLL     = 0;

	// ***************************************************************
	// Carrier types
	// ***************************************************************
	typedef enum logic [1:0] {
		M_IDLE = 2'b00,
		M_WAIT = 2'b01,
		M_CSWW = 2'b10
	} bpm_merge_t;

	// One decoded beacon, presented for one cycle with rx_valid
	typedef struct packed {
		logic               sig;
		logic [3:0]         slot;
		logic [4:0]         len;
		logic               movable;
		logic               switch_el;
		logic               resv_alien;
		logic [15:0]        occ_map;
		logic [15:0]        mov_map;
		logic               own_occ;
		logic               own_owner_me;
		logic               own_owner_bcst;
		logic signed [31:0] delta;
	} bpm_rx_t;

	// What was heard in our own slot while skipping
	typedef struct packed {
		logic hdr_beacon;
		logic activity_nohdr;
	} bpm_own_slot_t;

endpackage : bpm_pkg

// ---- rtl/bpm_hist.sv ----
// Per-slot occupancy history and contraction risk counters.
// Assumes sf_end is a one-cycle pulse at the end of each superframe.
`timescale 1ns/10ps
module bpm_hist
	import bpm_pkg::*;
(
	// Clock and reset
	input  wire logic              ref_clk,
	input  wire logic              rst,
	// Superframe events
	input  wire logic              sf_end,
	input  wire logic [NSLOT-1:0]  occ_seen,
	input  wire logic [NSLOT-1:0]  risk_set,
	// Slot state
	output      logic [NSLOT-1:0]  avail,
	output      logic [NSLOT-1:0]  contract_avail
);

	localparam logic [2:0] AGE_FULL = 3'(LOST_BEACON_LIMIT + 1);
	localparam logic [2:0] RISK_MAX = 3'(MOVABLE_LATENCY_LIMIT);

	logic [2:0] age  [NSLOT];
	logic [2:0] risk [NSLOT];

	// Clean-superframe age per slot, saturating
	always_ff @(posedge ref_clk)
	begin
		for (int i = 0; i < NSLOT; i++)
		begin
			if (rst)
				age[i] <= AGE_FULL;
			else if (sf_end)
				age[i] <= occ_seen[i] ? 3'h0 : ((age[i] == AGE_FULL) ? AGE_FULL : age[i] + 3'h1);
		end
	end

	// Slots judged risky are held occupied for contraction only
	always_ff @(posedge ref_clk)
	begin
		for (int i = 0; i < NSLOT; i++)
		begin
			if (rst)
				risk[i] <= 3'h0;
			else if (sf_end)
				risk[i] <= risk_set[i] ? RISK_MAX : ((risk[i] != 3'h0) ? risk[i] - 3'h1 : 3'h0);
		end
	end

	always_comb
	begin
		for (int i = 0; i < NSLOT; i++)
		begin
			avail[i]          = (age[i] == AGE_FULL);
			contract_avail[i] = (age[i] == AGE_FULL) && (risk[i] == 3'h0);
		end
	end

endmodule : bpm_hist

// ---- rtl/bpm_top.sv ----
// Beacon period manager: collision detection, contraction and group merge.
// Assumes decoded beacons and superframe/medium-slot timing from the same clock.
//
// The placing of the registers and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/10ps
// Overview of operation
// - Collision when a beacon reports our slot owned by another address.
// - Collision when same-slot beacons report our slot broadcast-owned for limit superframes.
// - After a skipped superframe, any report of our slot occupied is a collision.
// - While skipping, beacon header or headerless activity in our slot is a collision.
// - Beacon movable when an available slot lies between start and our slot.
// - Risky unoccupied slots count as occupied for contraction, up to latency limit.
// - Beacon never movable while the sleep announce element is carried.
// - Move to earliest available slot after limit-plus-one clean movable superframes.
// - Do not move when a movable neighbour's length excluded our slot recently.
// - Starts within twice the guard interval are aligned; others are foreign.
// - Overlap when either period start lies inside the other period.
// - Signalling window beacons are never foreign-group beacons.
// - Keep using a missing foreign beacon's contents up to the lost limit.
// - On overlap adopt foreign start; new slot is old plus one plus highest.
// - After relocation send no beacon in the former period.
// - Wait random zero to prior length superframes before a signalling beacon.
// - Reserve medium slots covering a non-overlapping foreign period, extra if misaligned.
// - Size the reservation by the largest foreign period length reported.
// - Relocate within merge wait, or one and a half times in second half.
// - Never relocate into a foreign period carrying a period switch element.
// - Keep our slot while a foreign reservation is seen, except merge or collision.
// - Listen for beacons throughout the reserved medium slots.
// - Skip our beacon now and then, never beyond the neighbour detect interval.
// - A slot is available only if unoccupied for limit-plus-one superframes.
module bpm_top
	import bpm_pkg::*;
#(
	parameter int P_BSLOT_CYC = BSLOT_CYC,
	parameter int P_MSLOT_CYC = MSLOT_CYC,
	parameter int P_SF_CYC    = SF_CYC
)
(
	// Clock and reset
	input  wire logic               ref_clk,
	input  wire logic               rst,
	// Superframe timing
	input  wire logic               sf_end,
	input  wire logic [7:0]         cur_ms,
	// Received beacons
	input  wire logic               rx_valid,
	input  wire bpm_rx_t            rx,
	input  wire bpm_own_slot_t      own_heard,
	// Beacon control outputs
	output      logic               tx_en,
	output      logic               skip_now,
	output      logic [3:0]         own_slot,
	output      logic               relocate,
	output      logic signed [31:0] start_shift,
	output      logic               join_req,
	output      logic               csw_grant,
	output      logic               listen_resv,
	// AXI4-Lite slave
	input  wire logic [7:0]         s_axi_awaddr,
	input  wire logic               s_axi_awvalid,
	output      logic               s_axi_awready,
	input  wire logic [31:0]        s_axi_wdata,
	input  wire logic [3:0]         s_axi_wstrb,
	input  wire logic               s_axi_wvalid,
	output      logic               s_axi_wready,
	output      logic [1:0]         s_axi_bresp,
	output      logic               s_axi_bvalid,
	input  wire logic               s_axi_bready,
	input  wire logic [7:0]         s_axi_araddr,
	input  wire logic               s_axi_arvalid,
	output      logic               s_axi_arready,
	output      logic [31:0]        s_axi_rdata,
	output      logic [1:0]         s_axi_rresp,
	output      logic               s_axi_rvalid,
	input  wire logic               s_axi_rready
);

	// ***************************************************************
	// Helpers
	// ***************************************************************
	function automatic logic [4:0] first_from(input logic [NSLOT-1:0] m, input int lo);
		logic [4:0] r;
		r = 5'h10;
		for (int i = NSLOT - 1; i >= 0; i--)
			if (m[i] && i >= lo)
				r = 5'(i);
		return r;
	endfunction : first_from

	function automatic logic [3:0] highest(input logic [NSLOT-1:0] m);
		logic [3:0] r;
		r = 4'h0;
		for (int i = 0; i < NSLOT; i++)
			if (m[i])
				r = 4'(i);
		return r;
	endfunction : highest

	function automatic logic [NSLOT-1:0] above(input logic [3:0] s);
		logic [NSLOT-1:0] r;
		for (int i = 0; i < NSLOT; i++)
			r[i] = (i > int'(s));
		return r;
	endfunction : above

	// ***************************************************************
	// State
	// ***************************************************************
	logic [31:0]      ctrl;
	logic [NSLOT-1:0] risk_map;
	logic             coll_st;
	logic             movable;
	logic             skip_prev;
	logic [NSLOT-1:0] occ_seen;
	logic [NSLOT-1:0] bc_seen;
	logic [1:0]       bc_cnt [NSLOT];
	logic             coll_sf;
	logic             nb_after_mov;
	logic             len_excl;
	logic             resv_seen;
	logic [2:0]       ok_cnt;
	logic [2:0]       excl_age;
	logic [2:0]       skip_cnt;
	logic [15:0]      lfsr;
	logic             fvalid;
	logic             fheard;
	logic [1:0]       fmiss;
	logic signed [31:0] fdelta;
	logic [4:0]       flen;
	logic [3:0]       fhigh;
	logic             fswitch;
	logic             overlap;
	logic             hold;
	logic [7:0]       resv_start;
	logic [7:0]       resv_cnt;
	logic             resv_valid;
	logic [4:0]       reloc_len;
	bpm_merge_t       mstate;
	logic [4:0]       wait_cnt;
	logic [NSLOT-1:0] avail;
	logic [NSLOT-1:0] cavail;
	logic             aligned;
	logic             rx_foreign;
	logic             coll_ev;
	logic             movable_now;
	logic [4:0]       earliest;
	logic [4:0]       own_len;
	logic [31:0]      foff;
	logic [4:0]       new_slot;
	logic             do_reloc;

	assign own_len = ctrl[CTRL_LEN_LO +: 5];

	bpm_hist u_hist (
		.ref_clk        (ref_clk),
		.rst            (rst),
		.sf_end         (sf_end),
		.occ_seen       (occ_seen),
		.risk_set       (risk_map | (coll_sf ? (16'h0001 << own_slot) : 16'h0000)),
		.avail          (avail),
		.contract_avail (cavail)
	);

	// ***************************************************************
	// Classification of received beacons
	// ***************************************************************
	always_comb
	begin
		aligned     = (rx.delta < 32'sd0 ? -rx.delta : rx.delta) < GUARD2_CYC;
		rx_foreign  = rx_valid && !rx.sig && !aligned;
		coll_ev     = 1'b0;
		if (rx_valid && aligned && rx.own_occ && !rx.own_owner_me && !rx.own_owner_bcst)
			coll_ev = 1'b1;
		if (rx_valid && aligned && rx.own_occ && skip_prev)
			coll_ev = 1'b1;
		if (skip_now && (own_heard.hdr_beacon || own_heard.activity_nohdr))
			coll_ev = 1'b1;
		for (int i = 0; i < NSLOT; i++)
			if (bc_seen[i] && bc_cnt[i] == 2'(LOST_BEACON_LIMIT - 1) && sf_end)
				coll_ev = 1'b1;
		movable_now = ((cavail & ~above(own_slot) & ~(16'h0001 << own_slot)) >> SIG_SLOTS) != 16'h0
			&& !ctrl[CTRL_HIB];
		earliest    = first_from(avail, SIG_SLOTS);
		foff        = (fdelta < 32'sd0) ? 32'(fdelta + P_SF_CYC) : 32'(fdelta);
		overlap     = (fdelta < 32'sd0) ? (32'(-fdelta) < 32'(flen) * 32'(P_BSLOT_CYC))
			: (32'(fdelta) < 32'(own_len) * 32'(P_BSLOT_CYC));
		new_slot    = 5'(own_slot) + 5'h1 + 5'(fhigh);
		do_reloc    = sf_end && fvalid && !fswitch && ctrl[CTRL_EN]
			&& ((mstate == M_IDLE && overlap) || (mstate == M_WAIT && wait_cnt == 5'h0));
	end

	// ***************************************************************
	// Per-superframe accumulators
	// ***************************************************************
	always_ff @(posedge ref_clk)
	begin
		if (rst || sf_end)
		begin
			occ_seen     <= 16'h0001 << own_slot;
			bc_seen      <= 16'h0000;
			coll_sf      <= 1'b0;
			nb_after_mov <= 1'b0;
			len_excl     <= 1'b0;
			resv_seen    <= 1'b0;
		end
		else
		begin
			if (rx_valid && aligned)
			begin
				occ_seen <= occ_seen | rx.occ_map;
				if (rx.own_occ && rx.own_owner_bcst)
					bc_seen[rx.slot] <= 1'b1;
				if ((rx.slot > own_slot && rx.movable) || (rx.mov_map & above(own_slot)) != 16'h0)
					nb_after_mov <= 1'b1;
				if (rx.movable && rx.len <= 5'(own_slot))
					len_excl <= 1'b1;
				if (rx.resv_alien)
					resv_seen <= 1'b1;
			end
			if (coll_ev)
				coll_sf <= 1'b1;
		end
	end

	// Consecutive broadcast-owner reports per sending slot
	always_ff @(posedge ref_clk)
	begin
		for (int i = 0; i < NSLOT; i++)
		begin
			if (rst)
				bc_cnt[i] <= 2'h0;
			else if (sf_end)
				bc_cnt[i] <= bc_seen[i] ? ((bc_cnt[i] == 2'h3) ? 2'h3 : bc_cnt[i] + 2'h1) : 2'h0;
		end
	end

	// ***************************************************************
	// Contraction and skipping
	// ***************************************************************
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			ok_cnt   <= 3'h0;
			excl_age <= 3'h7;
			movable  <= 1'b0;
			hold     <= 1'b0;
		end
		else if (sf_end)
		begin
			movable  <= movable_now;
			hold     <= resv_valid || resv_seen;
			excl_age <= len_excl ? 3'h0 : ((excl_age == 3'h7) ? 3'h7 : excl_age + 3'h1);
			if (movable_now && !nb_after_mov && !coll_sf && !coll_ev)
				ok_cnt <= (ok_cnt == 3'h7) ? 3'h7 : ok_cnt + 3'h1;
			else
				ok_cnt <= 3'h0;
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			skip_cnt  <= 3'h0;
			skip_now  <= 1'b0;
			skip_prev <= 1'b0;
			lfsr      <= 16'hace1;
		end
		else
		begin
			lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
			if (sf_end)
			begin
				skip_prev <= skip_now;
				if (skip_cnt == 3'(NEIGHBOUR_DETECT_INTERVAL - 1)
					|| (lfsr[0] && lfsr[5] && skip_cnt >= 3'(NEIGHBOUR_DETECT_INTERVAL / 2)))
				begin
					skip_now <= 1'b1;
					skip_cnt <= 3'h0;
				end
				else
				begin
					skip_now <= 1'b0;
					skip_cnt <= skip_cnt + 3'h1;
				end
			end
		end
	end

	// ***************************************************************
	// Foreign group memory
	// ***************************************************************
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			fvalid  <= 1'b0;
			fheard  <= 1'b0;
			fmiss   <= 2'h0;
			fdelta  <= 32'sd0;
			flen    <= 5'h0;
			fhigh   <= 4'h0;
			fswitch <= 1'b0;
		end
		else if (rx_foreign)
		begin
			fvalid  <= 1'b1;
			fheard  <= 1'b1;
			fdelta  <= rx.delta;
			flen    <= (fvalid && flen > rx.len) ? flen : rx.len;
			fhigh   <= fvalid ? ((fhigh > highest(rx.occ_map | (16'h0001 << rx.slot))) ? fhigh
				: highest(rx.occ_map | (16'h0001 << rx.slot))) : highest(rx.occ_map | (16'h0001 << rx.slot));
			fswitch <= (fvalid && fswitch) || rx.switch_el;
		end
		else if (sf_end)
		begin
			fheard <= 1'b0;
			if (do_reloc)
				fvalid <= 1'b0;
			else if (!fheard)
			begin
				fmiss <= fmiss + 2'h1;
				if (fmiss == 2'(LOST_BEACON_LIMIT - 1))
					fvalid <= 1'b0;
			end
			else
				fmiss <= 2'h0;
		end
	end

	// ***************************************************************
	// Merge sequencing and slot ownership
	// ***************************************************************
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			mstate      <= M_IDLE;
			wait_cnt    <= 5'h0;
			own_slot    <= SLOT_RST;
			relocate    <= 1'b0;
			start_shift <= 32'sd0;
			join_req    <= 1'b0;
			csw_grant   <= 1'b0;
			reloc_len   <= 5'h0;
		end
		else
		begin
			relocate  <= 1'b0;
			csw_grant <= 1'b0;
			if (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid && s_axi_awaddr == ADDR_SLOT
				&& s_axi_wstrb[0])
				own_slot <= s_axi_wdata[3:0];
			else if (do_reloc)
			begin
				relocate    <= 1'b1;
				start_shift <= fdelta;
				join_req    <= new_slot[4];
				own_slot    <= new_slot[3:0];
				reloc_len   <= own_len;
				wait_cnt    <= 5'(({11'h0, lfsr[4:0]}) % ({11'h0, own_len} + 16'h1));
				mstate      <= ctrl[CTRL_CSWREQ] ? M_CSWW : M_IDLE;
			end
			else if (sf_end)
			begin
				join_req <= 1'b0;
				unique case (mstate)
					M_IDLE:
					begin
						if (fvalid && !fswitch && ctrl[CTRL_EN])
						begin
							mstate   <= M_WAIT;
							wait_cnt <= (foff >= 32'(P_SF_CYC / 2)) ? 5'(MERGE_WAIT_LONG - 1)
								: 5'(MERGE_WAIT_TIME - 1);
						end
						else if (fvalid == 1'b0 && !hold && !coll_sf && !coll_ev
							&& ok_cnt >= 3'(LOST_BEACON_LIMIT) && movable_now && !nb_after_mov
							&& excl_age >= 3'(LOST_BEACON_LIMIT) && earliest < 5'(own_slot)
							&& !len_excl)
							own_slot <= earliest[3:0];
					end
					M_WAIT:
					begin
						if (!fvalid || fswitch)
							mstate <= M_IDLE;
						else
							wait_cnt <= wait_cnt - 5'h1;
					end
					M_CSWW:
					begin
						if (wait_cnt == 5'h0)
						begin
							csw_grant <= 1'b1;
							mstate    <= M_IDLE;
						end
						else
							wait_cnt <= wait_cnt - 5'h1;
					end
				endcase
			end
		end
	end

	// ***************************************************************
	// Reservation over a non-overlapping foreign period
	// ***************************************************************
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			resv_valid  <= 1'b0;
			resv_start  <= 8'h00;
			resv_cnt    <= 8'h00;
			listen_resv <= 1'b0;
			tx_en       <= 1'b0;
		end
		else
		begin
			if (sf_end)
			begin
				resv_valid <= fvalid && !overlap && !do_reloc;
				resv_start <= 8'(foff / 32'(P_MSLOT_CYC));
				resv_cnt   <= 8'((foff + 32'(flen) * 32'(P_BSLOT_CYC) + 32'(P_MSLOT_CYC) - 32'h1)
					/ 32'(P_MSLOT_CYC) - foff / 32'(P_MSLOT_CYC));
			end
			listen_resv <= resv_valid && cur_ms >= resv_start
				&& {1'b0, cur_ms} < {1'b0, resv_start} + {1'b0, resv_cnt};
			tx_en       <= ctrl[CTRL_EN] && !skip_now && !relocate && !join_req
				&& !sf_end;
		end
	end

	// ***************************************************************
	// AXI4-Lite register slave
	// ***************************************************************
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			ctrl         <= CTRL_RST;
			risk_map     <= 16'h0000;
			coll_st      <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= 2'b00;
		end
		else
		begin
			if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
			if (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid)
			begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (s_axi_awaddr <= ADDR_RISK && s_axi_awaddr[1:0] == 2'b00) ? 2'b00 : 2'b10;
				for (int b = 0; b < 4; b++)
					if (s_axi_wstrb[b] && s_axi_awaddr == ADDR_CTRL)
						ctrl[b*8 +: 8] <= s_axi_wdata[b*8 +: 8];
				if (s_axi_awaddr == ADDR_RISK && s_axi_wstrb[0])
					risk_map[7:0] <= s_axi_wdata[7:0];
				if (s_axi_awaddr == ADDR_RISK && s_axi_wstrb[1])
					risk_map[15:8] <= s_axi_wdata[15:8];
			end
			if (sf_end && coll_ev)
				coll_st <= 1'b1;
			else if (coll_ev)
				coll_st <= 1'b1;
			else if (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid && s_axi_awaddr == ADDR_STATUS
				&& s_axi_wstrb[0] && s_axi_wdata[ST_COLL])
				coll_st <= 1'b0;
		end
	end

	assign s_axi_awready = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
	assign s_axi_wready  = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;

	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= 2'b00;
		end
		else
		begin
			s_axi_arready <= 1'b0;
			if (s_axi_rvalid && s_axi_rready)
				s_axi_rvalid <= 1'b0;
			else if (s_axi_arvalid && !s_axi_rvalid && !s_axi_arready)
			begin
				s_axi_arready <= 1'b1;
				s_axi_rvalid  <= 1'b1;
				s_axi_rresp   <= 2'b00;
				unique case (s_axi_araddr)
					ADDR_CTRL:   s_axi_rdata <= ctrl;
					ADDR_STATUS: s_axi_rdata <= {24'h0, 1'b0, hold, join_req, mstate == M_WAIT,
						overlap && fvalid, fvalid, movable, coll_st};
					ADDR_SLOT:   s_axi_rdata <= {28'h0, own_slot};
					ADDR_RESV:   s_axi_rdata <= {15'h0, resv_valid, resv_cnt, resv_start};
					ADDR_RISK:   s_axi_rdata <= {16'h0, risk_map};
					default:
					begin
						s_axi_rdata <= 32'h0000_0000;
						s_axi_rresp <= 2'b10;
					end
				endcase
			end
		end
	end

endmodule : bpm_top

// ---- test/bpm_sva.sv ----
// Checker for bpm_top ports: bus handshakes and beacon outputs.
// Assumes it is bound into bpm_top.
`timescale 1ns/10ps
module bpm_sva
	import bpm_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Beacon outputs
	input wire logic tx_en,
	input wire logic skip_now,
	input wire logic relocate,
	input wire logic csw_grant,
	// Bus
	input wire logic s_axi_awvalid,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	sequence wr_take; s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid; endsequence
	sequence rd_take; s_axi_arvalid && !s_axi_rvalid && !s_axi_arready; endsequence
	chk_aw_term: assert property (s_axi_awready == (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid))
		else $error("awready wrong");
	chk_wr_answer: assert property (wr_take |=> s_axi_bvalid) else $error("no bvalid");
	chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid");
	chk_rd_answer: assert property (rd_take |=> s_axi_arready && s_axi_rvalid) else $error("no rvalid");
	chk_ar_pulse: assert property (s_axi_arready |=> !s_axi_arready) else $error("arready long");
	chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid) else $error("rvalid");
	chk_skip_tx: assert property (skip_now |-> !tx_en) else $error("sent while skipping");
	chk_reloc_pulse: assert property (relocate |=> !relocate) else $error("relocate long");
	chk_csw_pulse: assert property (csw_grant |=> !csw_grant) else $error("grant long");
	chk_reloc_quiet: assert property (relocate |-> !tx_en) else $error("sent at relocation");
endmodule : bpm_sva
bind bpm_top bpm_sva chk (.*);

// ---- test/bpm_peer.sv ----
// Neighbour model: presents beacons decoded from other devices.
// Assumes send_beacon is called just after a rising ref_clk edge.
`timescale 1ns/10ps
module bpm_peer
	import bpm_pkg::*;
(
	// Clock
	input wire logic ref_clk,
	// Beacon stream
	output logic          rx_valid,
	output bpm_rx_t       rx,
	output bpm_own_slot_t own_heard
);
	initial
	begin
		rx_valid = 1'b0;
		rx = '0;
		own_heard = '0;
	end
	task automatic send_beacon(input bpm_rx_t b);
		rx <= b;
		rx_valid <= 1'b1;
		@(posedge ref_clk);
		rx_valid <= 1'b0;
		// Released stream shows no stale beacon
		rx <= ~b;
	endtask : send_beacon
	// What our own slot yields while we skip, for one cycle
	task automatic hear_own(input bpm_own_slot_t h);
		own_heard <= h;
		@(posedge ref_clk);
		own_heard <= '0;
	endtask : hear_own
endmodule : bpm_peer

// ---- test/beacon_period_manager_test.sv ----
// Bench for bpm_top: registers, collision flags, foreign periods.
// Assumes bpm_sva and bpm_peer are compiled first.
`timescale 1ns/10ps
module beacon_period_manager_test import bpm_pkg::*;;
	logic ref_clk = 1'b0, rst = 1'b1, sf_end = 1'b0, rx_valid;
	logic [7:0] cur_ms = 8'h00, s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_awready, s_axi_wready;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
	logic signed [31:0] start_shift;
	logic [3:0] s_axi_wstrb = 4'hf, own_slot;
	logic [1:0] s_axi_bresp, s_axi_rresp, rr;
	logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, tx_en, skip_now, relocate;
	logic join_req, csw_grant, listen_resv;
	logic [2:0] hs;
	bpm_rx_t rx, b;
	bpm_own_slot_t own_heard;
	int fails = 0, tests_run = 0, relocs = 0;
	assign hs = {s_axi_rvalid, s_axi_bvalid, s_axi_awready};
	always #5 ref_clk = ~ref_clk;
	always @(posedge ref_clk) if (relocate === 1'b1) relocs++;
	bpm_top #(.P_BSLOT_CYC(20), .P_MSLOT_CYC(64), .P_SF_CYC(20000)) uut (.*);
	bpm_peer peer (.ref_clk(ref_clk), .rx_valid(rx_valid), .rx(rx), .own_heard(own_heard));
	// *****
	// Checks and bus tasks
	// *****
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			fails++;
			$display("FAIL at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic final_report;
		$display("comparisons %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : final_report
	task automatic tick_until(input int k);
		int n;
		n = 0;
		do @(posedge ref_clk); while (hs[k] !== 1'b1 && ++n < 50);
		if (n >= 50)
		begin
			fails++;
			final_report;
		end
	endtask : tick_until
	task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		tick_until(0);
		s_axi_awvalid <= 1'b0;
		s_axi_wvalid <= 1'b0;
		tick_until(1);
		s_axi_bready <= 1'b0;
		@(posedge ref_clk);
	endtask : axi_write
	task automatic axi_read(input logic [7:0] a);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		tick_until(2);
		rd = s_axi_rdata;
		rr = s_axi_rresp;
		s_axi_arvalid <= 1'b0;
		s_axi_rready <= 1'b0;
		@(posedge ref_clk);
	endtask : axi_read
	task automatic sframe(input logic e);
		peer.send_beacon(b);
		sf_end <= e;
		@(posedge ref_clk);
		sf_end <= 1'b0;
		repeat (3) @(posedge ref_clk);
		axi_read(ADDR_STATUS);
	endtask : sframe
	initial
	begin
		repeat (6) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		axi_read(ADDR_CTRL);
		check(rd, CTRL_RST);
		axi_read(8'h40);
		check({rd[29:0], rr}, 32'h2);
		check(32'(own_slot), 32'(SLOT_RST));
		axi_write(ADDR_SLOT, 32'h5);
		check(32'(own_slot), 32'h5);
		$display("register test done");
		for (int i = 0; i < 3; i++)
		begin
			b = '0;
			b.own_occ = 1'b1;
			b.own_owner_me = (i == 0);
			b.own_owner_bcst = (i == 1);
			sframe(1'b0);
			check(32'(rd[ST_COLL]), 32'(i == 2));
			axi_write(ADDR_STATUS, 32'h1);
		end
		$display("owner collision test done");
		b.own_owner_bcst = 1'b1;
		for (int i = 0; i < 3; i++)
		begin
			sframe(1'b1);
			check(32'(rd[ST_COLL]), 32'(i == 2));
		end
		axi_write(ADDR_STATUS, 32'h1);
		$display("broadcast collision test done");
		b = '0;
		b.sig = 1'b1;
		b.delta = 5000;
		sframe(1'b1);
		check(32'(rd[2]), 32'h0);
		b.sig = 1'b0;
		b.delta = GUARD2_CYC - 1;
		sframe(1'b1);
		check(32'(rd[2]), 32'h0);
		b.delta = 5000;
		sframe(1'b1);
		check(32'(rd[3:2]), 32'h1);
		repeat (9) sframe(1'b1);
		check(relocs, 32'h1);
		check(start_shift, 32'd5000);
		check(32'(own_slot), 32'h6);
		axi_read(ADDR_RESV);
		check(rd, 32'h0001_014e);
		cur_ms <= 8'h4e;
		repeat (2) @(posedge ref_clk);
		check(32'(listen_resv), 32'h1);
		$display("foreign period test done");
		for (int n = 0; n < 9 && skip_now !== 1'b1; n++)
			sframe(1'b1);
		check(32'(skip_now), 32'h1);
		check(32'(tx_en), 32'h0);
		axi_write(ADDR_STATUS, 32'h1);
		peer.hear_own(2'b01);
		@(posedge ref_clk);
		axi_read(ADDR_STATUS);
		check(32'(rd[ST_COLL]), 32'h1);
		$display("skip test done");
		final_report;
	end
endmodule : beacon_period_manager_test
